// ---- core/fplc_pkg.sv ----
// constants for the flash program launch control block
// shared by the control top and its busy timer
package fplc_pkg;
	localparam logic [7:0] FLASH_CONTROL_OFFSET = 8'hd1;
	localparam logic [7:0] FLASH_CONTROL_RESET = 8'h00;
	localparam int KEY_MSB = 7;
	localparam int KEY_LSB = 4;
	localparam int MAP_BIT = 3;
	localparam int SEL_MSB = 2;
	localparam int SEL_LSB = 1;
	localparam int BUSY_BIT = 0;
	localparam logic [3:0] KEY_UNLOCK = 4'h5;
	localparam logic [3:0] KEY_LAUNCH = 4'ha;
	localparam logic [1:0] SPACE_USER = 2'h0;
	localparam logic [1:0] SPACE_XROW = 2'h1;
	localparam logic [1:0] SPACE_SECURITY = 2'h2;
	localparam logic [1:0] SPACE_RESERVED = 2'h3;
	localparam int PAGE_BYTES = 128;
	localparam int BYTE_IDX_W = 7;
	localparam int PAGE_IDX_W = 8;
	localparam int PAGE_MSB = 14;
	localparam int PAGE_LSB = 7;
	localparam int USER_BYTES = 32768;
	localparam int USER_ADDR_W = 15;
	localparam logic [8:0] XROW_TOP_BITS = 9'h1ff;
	localparam logic [15:0] SECURITY_ADDR = 16'h0000;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] SECURITY_SW_MASK = 8'hf0;
	localparam logic [7:0] NO_DATA = 8'h00;
	localparam int CLK_MHZ = 100;
	localparam int PROG_TIME_MS = 10;
	localparam int PROG_CYCLES = PROG_TIME_MS * 1000 * 1000 * CLK_MHZ / 1000;
	localparam int TIMER_W = 20;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ERASE,
		ST_PROGRAM,
		ST_WAIT
	} fplc_state_type;
endpackage : fplc_pkg

// ---- core/fplc_busy_timer.sv ----
// busy time counter for one erase-and-program operation
// start is a one-cycle pulse from the control top on the same clock
`timescale 1ns/1ps
module fplc_busy_timer
	import fplc_pkg::*;
#(
	parameter int CYCLES = PROG_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rstSyncN,
	input wire logic start,
	output logic done
);
	logic [TIMER_W-1:0] count_q;
	logic running_q;
	logic done_q;

	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			count_q <= '0;
			running_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				count_q <= TIMER_W'(CYCLES - 1);
				running_q <= 1'b1;
			end else if (running_q) begin
				if (count_q == '0) begin
					running_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					count_q <= count_q - 1'b1;
				end
			end
		end
	end

	assign done = done_q;
endmodule : fplc_busy_timer

// ---- core/flash_program_launch_control.sv ----
// flash control register, page latches, launch sequencer and flash spaces
// the core drives register, latch-write and code-read strobes on sys_clk
//
// Summary of operation
// - 50h then A0h programs user array
// - 52h then A2h programs extra row
// - 54h then A4h programs security byte
// - 0Ch maps latches, security byte loads at 0000h
// - last loaded page address is programming target
// - 00h maps user array for code reads
// - 02h maps extra row at FF80h-FFFFh
// - 04h maps security byte at 0000h
// - key 5 then A launches selected space
// - bit 3 redirects data writes to latches
// - busy bit hardware only, software cannot clear
// - bits 2-1 select space for read, launch
// - control register resets to zero
// - launch erases loaded locations, then programs
// - busy lasts about 10 ms
// - byte or page programming by loaded count
// - select 11 reserved, launch does nothing
// - address bits 6-0 byte, 14-7 page
// - core held idle while busy
`timescale 1ns/1ps
module flash_program_launch_control
	import fplc_pkg::*;
#(
	parameter int PROG_CYCLES_P = PROG_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic [15:0] xdataAddr,
	input wire logic [7:0] xdataWrData,
	input wire logic xdataWr,
	output logic latchMapEnable,
	input wire logic [15:0] codeRdAddr,
	input wire logic codeRd,
	output logic [7:0] codeRdData,
	output logic cpuIdle
);
	function automatic logic isControl(input logic [7:0] addr);
		return addr == FLASH_CONTROL_OFFSET;
	endfunction : isControl

	function automatic logic isXrowAddr(input logic [15:0] addr);
		return addr[15:PAGE_LSB] == XROW_TOP_BITS;
	endfunction : isXrowAddr

	// key and select fields of a control write
	function automatic logic [3:0] keyField(input logic [7:0] value);
		return value[KEY_MSB:KEY_LSB];
	endfunction : keyField

	function automatic logic [1:0] selField(input logic [7:0] value);
		return value[SEL_MSB:SEL_LSB];
	endfunction : selField

	logic rstSync1_q;
	logic rstSync2_q;
	logic rstSyncN;

	logic [3:0] launchKey_q;
	logic latchMap_q;
	logic [1:0] spaceSelect_q;
	logic busy_q;
	logic unlockArmed_q;
	logic [7:0] regRdData_q;
	logic [7:0] codeRdData_q;
	logic cpuIdle_q;

	logic [7:0] latchData [0:PAGE_BYTES-1];
	logic [PAGE_BYTES-1:0] latchLoaded_q;
	logic [PAGE_IDX_W-1:0] lastPage_q;

	// flash contents keep no reset
	logic [7:0] userMem [0:USER_BYTES-1];
	logic [7:0] xrowMem [0:PAGE_BYTES-1];
	logic [7:0] securityByte;

	fplc_state_type state_q;
	logic [BYTE_IDX_W-1:0] walkIdx_q;
	logic [1:0] targetSpace_q;
	logic [PAGE_IDX_W-1:0] targetPage_q;

	logic ctlWrite;
	logic launchGo;
	logic timerDone;
	logic timeUp_q;
	logic opDone;
	logic walkLast;
	logic latchWrite;
	logic [7:0] walkByte;
	logic [USER_ADDR_W-1:0] walkUserAddr;
	logic [7:0] readByte;

	// reset release through two flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync1_q <= 1'b0;
			rstSync2_q <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstSync2_q <= rstSync1_q;
		end
	end
	assign rstSyncN = rstSync2_q;

	// control register decode
	assign ctlWrite = regWr && isControl(regAddr);
	// launch needs armed unlock, idle flash and a real space
	assign launchGo = ctlWrite && !busy_q && unlockArmed_q
		&& keyField(regWrData) == KEY_LAUNCH
		&& selField(regWrData) != SPACE_RESERVED;
	// latch loads refused while busy
	assign latchWrite = xdataWr && latchMap_q && !busy_q;
	assign walkLast = walkIdx_q == BYTE_IDX_W'(PAGE_BYTES - 1);
	assign walkByte = latchData[walkIdx_q];
	assign walkUserAddr = {targetPage_q, walkIdx_q};
	// operation ends once the walk is over and the time is up
	assign opDone = state_q == ST_WAIT && (timerDone || timeUp_q);

	// control register fields
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			launchKey_q <= FLASH_CONTROL_RESET[KEY_MSB:KEY_LSB];
			latchMap_q <= FLASH_CONTROL_RESET[MAP_BIT];
			spaceSelect_q <= FLASH_CONTROL_RESET[SEL_MSB:SEL_LSB];
		end else if (ctlWrite) begin
			latchMap_q <= regWrData[MAP_BIT];
			if (!busy_q) begin
				launchKey_q <= keyField(regWrData);
				spaceSelect_q <= selField(regWrData);
			end
		end
	end

	// unlock stays armed only until the next control write
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			unlockArmed_q <= 1'b0;
		end else if (ctlWrite && !busy_q) begin
			unlockArmed_q <= keyField(regWrData) == KEY_UNLOCK;
		end
	end

	// busy flag, written only by the sequencer
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			busy_q <= FLASH_CONTROL_RESET[BUSY_BIT];
		end else if (launchGo) begin
			busy_q <= 1'b1;
		end else if (opDone) begin
			busy_q <= 1'b0;
		end
	end

	// core idle follows the busy window
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			cpuIdle_q <= 1'b0;
		end else if (launchGo) begin
			cpuIdle_q <= 1'b1;
		end else if (opDone) begin
			cpuIdle_q <= 1'b0;
		end
	end

	// page latch data
	always_ff @(posedge sys_clk) begin
		if (latchWrite) begin
			latchData[xdataAddr[BYTE_IDX_W-1:0]] <= xdataWrData;
		end
	end

	// loaded marks and last page address
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			latchLoaded_q <= '0;
			lastPage_q <= '0;
		end else if (opDone) begin
			latchLoaded_q <= '0;
		end else if (latchWrite) begin
			latchLoaded_q[xdataAddr[BYTE_IDX_W-1:0]] <= 1'b1;
			lastPage_q <= xdataAddr[PAGE_MSB:PAGE_LSB];
		end
	end

	// erase-then-program sequencer
	// every byte index is walked; unloaded ones are skipped
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_q <= ST_IDLE;
			walkIdx_q <= '0;
			targetSpace_q <= SPACE_USER;
			targetPage_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (launchGo) begin
						state_q <= ST_ERASE;
						walkIdx_q <= '0;
						targetSpace_q <= selField(regWrData);
						targetPage_q <= lastPage_q;
					end
				end
				ST_ERASE: begin
					walkIdx_q <= walkIdx_q + 1'b1;
					if (walkLast) begin
						state_q <= ST_PROGRAM;
					end
				end
				ST_PROGRAM: begin
					walkIdx_q <= walkIdx_q + 1'b1;
					if (walkLast) begin
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (opDone) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// counts the busy time from the launch
	fplc_busy_timer #(
		.CYCLES(PROG_CYCLES_P)
	) busyTimer (
		.sys_clk(sys_clk),
		.rstSyncN(rstSyncN),
		.start(launchGo),
		.done(timerDone)
	);

	// a short time may run out before the walk ends
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			timeUp_q <= 1'b0;
		end else if (launchGo || opDone) begin
			timeUp_q <= 1'b0;
		end else if (timerDone) begin
			timeUp_q <= 1'b1;
		end
	end

	// programming only clears bits, hence the erase first
	// user array: only loaded locations touched
	always_ff @(posedge sys_clk) begin
		if (targetSpace_q == SPACE_USER && latchLoaded_q[walkIdx_q]) begin
			if (state_q == ST_ERASE) begin
				userMem[walkUserAddr] <= ERASED_BYTE;
			end else if (state_q == ST_PROGRAM) begin
				userMem[walkUserAddr] <= userMem[walkUserAddr] & walkByte;
			end
		end
	end

	// extra row
	always_ff @(posedge sys_clk) begin
		if (targetSpace_q == SPACE_XROW && latchLoaded_q[walkIdx_q]) begin
			if (state_q == ST_ERASE) begin
				xrowMem[walkIdx_q] <= ERASED_BYTE;
			end else if (state_q == ST_PROGRAM) begin
				xrowMem[walkIdx_q] <= xrowMem[walkIdx_q] & walkByte;
			end
		end
	end

	// security byte: software reaches the upper nibble only
	always_ff @(posedge sys_clk) begin
		if (targetSpace_q == SPACE_SECURITY && latchLoaded_q[0] && walkIdx_q == '0) begin
			if (state_q == ST_ERASE) begin
				securityByte <= securityByte | SECURITY_SW_MASK;
			end else if (state_q == ST_PROGRAM) begin
				securityByte <= securityByte & (walkByte | ~SECURITY_SW_MASK);
			end
		end
	end

	// code read through the mapped space
	always_comb begin
		readByte = ERASED_BYTE;
		if (!busy_q) begin
			case (spaceSelect_q)
				SPACE_USER: begin
					if (!codeRdAddr[USER_ADDR_W]) begin
						readByte = userMem[codeRdAddr[USER_ADDR_W-1:0]];
					end
				end
				SPACE_XROW: begin
					if (isXrowAddr(codeRdAddr)) begin
						readByte = xrowMem[codeRdAddr[BYTE_IDX_W-1:0]];
					end
				end
				SPACE_SECURITY: begin
					if (codeRdAddr == SECURITY_ADDR) begin
						readByte = securityByte;
					end
				end
				default: begin
					readByte = ERASED_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			codeRdData_q <= NO_DATA;
		end else begin
			codeRdData_q <= codeRd ? readByte : NO_DATA;
		end
	end

	// register read data stand for one cycle
	always_ff @(posedge sys_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			regRdData_q <= NO_DATA;
		end else if (regRd && isControl(regAddr)) begin
			regRdData_q <= {launchKey_q, latchMap_q, spaceSelect_q, busy_q};
		end else begin
			regRdData_q <= NO_DATA;
		end
	end

	// outputs come straight from flops
	assign regRdData = regRdData_q;
	assign codeRdData = codeRdData_q;
	assign latchMapEnable = latchMap_q;
	assign cpuIdle = cpuIdle_q;
endmodule : flash_program_launch_control

// ---- bench/fplc_checker_properties.sv ----
// port assertions for the flash launch control top
// bound into the top; sees its ports only
`timescale 1ns/1ps
module fplc_checker
	import fplc_pkg::*;
#(
	parameter int PROG_CYCLES_P = PROG_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	input wire logic latchMapEnable,
	input wire logic codeRd,
	input wire logic [7:0] codeRdData,
	input wire logic cpuIdle
);
	logic ctlWr;
	logic armed_q;
	logic map_q;
	logic [19:0] busyCnt_q;
	assign ctlWr = regWr && regAddr == FLASH_CONTROL_OFFSET;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_q <= 1'h0;
			map_q <= 1'h0;
		end else if (ctlWr) begin
			// key writes are ignored while busy, the map bit is not
			if (!cpuIdle) armed_q <= regWrData[KEY_MSB:KEY_LSB] == KEY_UNLOCK;
			map_q <= regWrData[MAP_BIT];
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) busyCnt_q <= 20'h0;
		else busyCnt_q <= cpuIdle ? busyCnt_q + 20'h1 : 20'h0;
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	a_map_follows_write: assert property (ctlWr |=> latchMapEnable == map_q)
		else $error("map output wrong");
	a_launch_starts_busy: assert property (ctlWr && armed_q && regWrData[7:4] == 4'ha
		&& regWrData[2:1] != 2'h3 && !cpuIdle |=> cpuIdle[*3])
		else $error("launch did not start");
	a_reserved_no_launch: assert property (ctlWr && regWrData[2:1] == 2'h3
		&& !cpuIdle |=> !cpuIdle)
		else $error("reserved space launched");
	a_launch_needs_unlock: assert property (ctlWr && !armed_q && !cpuIdle |=> !cpuIdle)
		else $error("launch without unlock");
	a_busy_bit_read: assert property (regRd && regAddr == 8'hd1
		|=> regRdData[0] == $past(cpuIdle))
		else $error("busy bit wrong");
	a_busy_time_span: assert property ($fell(cpuIdle) |-> busyCnt_q >= PROG_CYCLES_P - 2
		&& busyCnt_q <= PROG_CYCLES_P + 4)
		else $error("busy length wrong");
	a_code_blocked_busy: assert property (codeRd && cpuIdle |=> codeRdData == 8'hff)
		else $error("code read while busy");
	a_reset_all_clear: assert property ($rose(rst_n) |-> !cpuIdle && !latchMapEnable
		&& regRdData == 8'h00)
		else $error("outputs not clear");
endmodule : fplc_checker
bind flash_program_launch_control fplc_checker #(
	.PROG_CYCLES_P(PROG_CYCLES_P)
) u_chk (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWr(regWr),
	.regRd(regRd),
	.regRdData(regRdData),
	.latchMapEnable(latchMapEnable),
	.codeRd(codeRd),
	.codeRdData(codeRdData),
	.cpuIdle(cpuIdle)
);

// ---- bench/fplc_core_model.sv ----
// processor core model: register, latch-load and code-read cycles
// drives the block's request ports just after sys_clk rises
`timescale 1ns/1ps
module fplc_core_model (
	input wire logic sys_clk,
	input wire logic [7:0] regRdData,
	input wire logic [7:0] codeRdData,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWr,
	output logic regRd,
	output logic [15:0] xdataAddr,
	output logic [7:0] xdataWrData,
	output logic xdataWr,
	output logic [15:0] codeRdAddr,
	output logic codeRd
);
	initial begin
		{regAddr, regWrData, regWr, regRd} = '0;
		{xdataAddr, xdataWrData, xdataWr, codeRdAddr, codeRd} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) {regAddr, regWrData, regWr} <= {a, d, 1'h1};
		@(posedge sys_clk) {regWrData, regWr} <= {~d, 1'h0};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk) {regAddr, regRd} <= {a, 1'h1};
		@(posedge sys_clk) regRd <= 1'h0;
		#1 d = regRdData;
	endtask : rd
	task automatic xw(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk) {xdataAddr, xdataWrData, xdataWr} <= {a, d, 1'h1};
		@(posedge sys_clk) {xdataWrData, xdataWr} <= {~d, 1'h0};
	endtask : xw
	task automatic cr(input logic [15:0] a, output logic [7:0] d);
		@(posedge sys_clk) {codeRdAddr, codeRd} <= {a, 1'h1};
		@(posedge sys_clk) codeRd <= 1'h0;
		#1 d = codeRdData;
	endtask : cr
	// no interrupt sources here, so none left enabled at launch
	task automatic launch(input logic [1:0] sel);
		wr(8'hd1, {4'h5, 1'h0, sel, 1'h0});
		wr(8'hd1, {4'ha, 1'h0, sel, 1'h0});
	endtask : launch
endmodule : fplc_core_model

// ---- bench/test_flash_program_launch_control.sv ----
// self-checking bench for the flash launch control block
// busy time shortened to 300 cycles through the parameter
`timescale 1ns/1ps
module test_flash_program_launch_control
	import fplc_pkg::*;
;
	localparam int P = 300;
	localparam logic [7:0] C = FLASH_CONTROL_OFFSET;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] regAddr, regWrData, regRdData, xdataWrData, codeRdData, d;
	logic [15:0] xdataAddr, codeRdAddr;
	logic regWr, regRd, xdataWr, latchMapEnable, codeRd, cpuIdle;
	int mismatches = 0;
	int n_compared = 0;
	always #5 sys_clk = ~sys_clk;
	fplc_core_model core (
		.sys_clk(sys_clk),
		.regRdData(regRdData),
		.codeRdData(codeRdData),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWr(regWr),
		.regRd(regRd),
		.xdataAddr(xdataAddr),
		.xdataWrData(xdataWrData),
		.xdataWr(xdataWr),
		.codeRdAddr(codeRdAddr),
		.codeRd(codeRd)
	);
	flash_program_launch_control #(
		.PROG_CYCLES_P(P)
	) dut (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWr(regWr),
		.regRd(regRd),
		.regRdData(regRdData),
		.xdataAddr(xdataAddr),
		.xdataWrData(xdataWrData),
		.xdataWr(xdataWr),
		.latchMapEnable(latchMapEnable),
		.codeRdAddr(codeRdAddr),
		.codeRd(codeRd),
		.codeRdData(codeRdData),
		.cpuIdle(cpuIdle)
	);
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// poll busy under a bound, optionally checking its length
	task automatic done_op(input logic t);
		int n;
		n = 0;
		#1;
		while (cpuIdle === 1'h1 && n < 2000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n >= 2000) begin
			mismatches++;
			stop_test;
		end else if (t) check(n >= P - 2 && n <= P + 4, 1'h1);
	endtask : done_op
	initial begin
		#200000;
		mismatches++;
		stop_test;
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge sys_clk);
		core.wr(8'hd0, 8'hff);
		core.rd(8'hd0, d);
		check(d, 8'h00);
		core.rd(C, d);
		check(d, 8'h00);
		core.wr(C, 8'h0c);
		core.rd(C, d);
		check(d, 8'h0c);
		check(latchMapEnable, 1'h1);
		// second pass needs the erase: 33 then cc; 0106 loaded once, kept
		for (int i = 0; i < 2; i++) begin
			core.wr(C, 8'h08);
			core.xw(16'h0005, 8'h11);
			core.xw(16'h0105, i ? 8'hcc : 8'h33);
			if (i == 0) core.xw(16'h0106, 8'h44);
			core.launch(2'h0);
			done_op(1'h1);
		end
		core.wr(C, 8'h00);
		core.cr(16'h0105, d);
		check(d, 8'hcc);
		core.cr(16'h0106, d);
		check(d, 8'h44);
		core.cr(16'h8105, d);
		check(d, 8'hff);
		core.wr(C, 8'h0a);
		core.xw(16'hff85, 8'h5a);
		core.launch(2'h1);
		done_op(1'h1);
		core.wr(C, 8'h02);
		core.cr(16'hff85, d);
		check(d, 8'h5a);
		core.cr(16'h0105, d);
		check(d, 8'hff);
		core.wr(C, 8'h0c);
		core.xw(16'h0000, 8'h9c);
		core.launch(2'h2);
		core.rd(C, d);
		check(d, 8'ha5);
		core.wr(C, 8'h5a);
		core.rd(C, d);
		check(d, 8'had);
		core.cr(16'h0000, d);
		check(d, 8'hff);
		done_op(1'h0);
		core.wr(C, 8'h04);
		core.cr(16'h0000, d);
		check(d & 8'hf0, 8'h90);
		core.wr(C, 8'h50);
		core.wr(C, 8'h00);
		core.wr(C, 8'ha0);
		core.launch(2'h3);
		repeat (3) @(posedge sys_clk);
		#1;
		check(cpuIdle, 1'h0);
		stop_test;
	end
endmodule : test_flash_program_launch_control
